//--- eep_two_wire.sv
// Two-wire serial EEPROM target with a 2048 x 8 array and an APB control port.
//
// Functional notes
// - Sample data on clock rise, change on fall.
// - Data changes only while clock is low.
// - Data line is open drain, pull low only.
// - Data fall with clock high is start.
// - Data rise with clock high is stop.
// - Stop after write data launches programming cycle.
// - Programming cycle ends within 5 ms.
// - Eight-bit transfers, ninth clock is acknowledge.
// - Write: acknowledge every received byte.
// - Read: ack address, continue on host ack.
// - Host no-ack then stop ends read.
// - No ack nor stop: stay released, silent.
// - Address word: type, three bits, direction.
// - Direction 0 writes, 1 reads.
// - Three address bits are memory bits ten-eight.
// - Type mismatch: no ack, back to standby.
// - Protect pin high blocks upper half writes.
// - Reads work regardless of protect pin.
// - Array holds 2048 bytes, eleven-bit address.
// - Page program takes up to sixteen bytes.
// - Busy: write-direction address word not acknowledged.
// - Read address increments, wraps to zero.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.svh"

module eep_two_wire
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `EEP_PROG_TIME_MS * `EEP_CLK_KHZ,
  parameter logic [3:0]  TYPE_CODE   = 4'h5  // Arbitrary value.
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        write_protect
);

  // ****************************************************************
  // Pin synchronisers and bus event detection
  // ****************************************************************
  logic       scl_m, scl_s, scl_d;
  logic       sda_m, sda_s, sda_d;
  logic       wp_m, wp_s;
  logic       scl_rise, scl_fall, start_evt, stop_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_m  <= 1'b0;
      wp_s  <= 1'b0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m  <= write_protect;
      wp_s  <= wp_m;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_evt = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_evt  = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // APB registers
  // ****************************************************************
  logic                   enable;
  logic                   busy;
  logic [`EEP_ADDR_W-1:0] addr;

  function automatic logic [1:0] eep_decode(input logic [11:0] a);
    logic [1:0] sel;
    sel = 2'b00;
    if (a == `EEP_CTRL_OFFSET) begin
      sel = 2'b01;
    end else if (a == `EEP_STATUS_OFFSET) begin
      sel = 2'b10;
    end
    return sel;
  endfunction : eep_decode

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (eep_decode(paddr) == 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= `EEP_CTRL_RESET;
    end else if (psel && penable && pwrite && eep_decode(paddr) == 2'b01) begin
      enable <= pwdata[`EEP_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      case (eep_decode(paddr))
        2'b01: begin
          prdata[`EEP_CTRL_EN_BIT] <= enable;
        end
        2'b10: begin
          prdata[`EEP_STAT_BUSY_BIT]                   <= busy;
          prdata[`EEP_STAT_WP_BIT]                     <= wp_s;
          prdata[`EEP_STAT_ADDR_MSB:`EEP_STAT_ADDR_LSB] <= addr;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Serial protocol state machine
  // ****************************************************************
  eep_state_type          state;
  eep_state_type          after_ack;
  logic [3:0]             bitcnt;
  logic [7:0]             shreg;
  logic [7:0]             outbyte;
  logic [2:0]             hi_bits;
  logic                   drive_low;
  logic                   host_acked;
  logic                   wr_started;
  logic                   store_evt;
  logic                   launch;
  logic [7:0]             mem [`EEP_DEPTH];
  logic [`EEP_ADDR_W-1:0] next_addr;

  assign next_addr = addr + 11'h001;
  assign store_evt = scl_fall && state == EEP_WR_DATA && bitcnt == `EEP_BIT_LAST;
  assign launch    = stop_evt && wr_started;

  // Only pull-down is ever driven; the pull-up supplies the high level.
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= EEP_IDLE;
      after_ack  <= EEP_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      outbyte    <= 8'h00;
      hi_bits    <= 3'h0;
      addr       <= 11'h000;
      drive_low  <= 1'b0;
      host_acked <= 1'b0;
      wr_started <= 1'b0;
    end else if (stop_evt) begin
      state      <= EEP_IDLE;
      drive_low  <= 1'b0;
      wr_started <= 1'b0;
    end else if (start_evt) begin
      state      <= enable ? EEP_DEV_ADDR : EEP_IDLE;
      bitcnt     <= 4'h0;
      drive_low  <= 1'b0;
      wr_started <= 1'b0;
    end else if (scl_rise) begin
      // Incoming bits are taken on the rising clock edge.
      case (state)
        EEP_DEV_ADDR, EEP_MEM_ADDR, EEP_WR_DATA: begin
          shreg  <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        EEP_HOST_ACK: begin
          host_acked <= ~sda_s;
        end
        default: begin
          host_acked <= host_acked;
        end
      endcase
    end else if (scl_fall) begin
      // Everything driven changes just after the falling edge, so data only moves while the clock is low.
      case (state)
        EEP_DEV_ADDR: begin
          if (bitcnt == `EEP_BIT_LAST) begin
            bitcnt <= 4'h0;
            // A busy array refuses write-direction address words so polling sees the no-ack.
            if (shreg[7:4] == TYPE_CODE && !(busy && !shreg[0])) begin
              hi_bits   <= shreg[3:1];
              drive_low <= 1'b1;
              state     <= EEP_ACK;
              after_ack <= shreg[0] ? EEP_RD_DATA : EEP_MEM_ADDR;
            end else begin
              state <= EEP_IDLE;
            end
          end
        end
        EEP_MEM_ADDR: begin
          if (bitcnt == `EEP_BIT_LAST) begin
            bitcnt    <= 4'h0;
            addr      <= {hi_bits, shreg};
            drive_low <= 1'b1;
            state     <= EEP_ACK;
            after_ack <= EEP_WR_DATA;
          end
        end
        EEP_WR_DATA: begin
          if (bitcnt == `EEP_BIT_LAST) begin
            bitcnt     <= 4'h0;
            addr[3:0]  <= addr[3:0] + 4'h1;
            wr_started <= 1'b1;
            drive_low  <= 1'b1;
            state      <= EEP_ACK;
            after_ack  <= EEP_WR_DATA;
          end
        end
        EEP_ACK: begin
          state  <= after_ack;
          bitcnt <= 4'h0;
          if (after_ack == EEP_RD_DATA) begin
            outbyte   <= mem[addr];
            drive_low <= ~mem[addr][7];
          end else begin
            drive_low <= 1'b0;
          end
        end
        EEP_RD_DATA: begin
          if (bitcnt == 4'h7) begin
            drive_low <= 1'b0;
            state     <= EEP_HOST_ACK;
          end else begin
            outbyte   <= {outbyte[6:0], 1'b0};
            drive_low <= ~outbyte[6];
            bitcnt    <= bitcnt + 4'h1;
          end
        end
        EEP_HOST_ACK: begin
          // The byte just sent counts as accessed, so the current address moves on either way.
          addr <= next_addr;
          if (host_acked) begin
            outbyte   <= mem[next_addr];
            drive_low <= ~mem[next_addr][7];
            bitcnt    <= 4'h0;
            state     <= EEP_RD_DATA;
          end else begin
            state <= EEP_IDLE;
          end
        end
        default: begin
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Page buffer
  // ****************************************************************
  logic [7:0]                  pbuf [`EEP_PAGE_BYTES];
  logic [`EEP_PAGE_BYTES-1:0]  pvalid;
  logic [`EEP_ADDR_W-5:0]      page;
  logic                        prog_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pvalid <= '0;
      page   <= 7'h00;
    end else if (prog_done || (start_evt && !busy)) begin
      pvalid <= '0;
    end else if (store_evt && !busy) begin
      page <= addr[`EEP_ADDR_W-1:4];
      // Protected bytes are still acknowledged but never marked for programming.
      if (!(wp_s && addr[`EEP_ADDR_W-1])) begin
        pvalid[addr[3:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (store_evt && !busy) begin
      pbuf[addr[3:0]] <= shreg;
    end
  end

  // ****************************************************************
  // Internally timed programming cycle
  // ****************************************************************
  logic [31:0] prog_count;

  assign prog_done = busy && prog_count == 32'h0000_0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      prog_count <= 32'h0000_0000;
    end else if (launch && !busy) begin
      busy       <= 1'b1;
      // The stop reaches the counter a few pclk late through the synchronisers, so the count is
      // shortened by that much to keep the whole cycle within the limit.
      prog_count <= 32'(PROG_CYCLES) - 32'(`EEP_SYNC_EDGES);
    end else if (prog_done) begin
      busy       <= 1'b0;
      prog_count <= 32'h0000_0000;
    end else if (busy) begin
      prog_count <= prog_count - 32'h0000_0001;
    end
  end

  // The bytes marked for programming commit together at the end of the cycle, so a read during the cycle sees old data.
  logic [`EEP_PAGE_BYTES-1:0] commit_we;

  generate
    for (genvar i = 0; i < `EEP_PAGE_BYTES; i++) begin : g_commit
      assign commit_we[i] = prog_done & pvalid[i];
    end
  endgenerate

  // One process owns the array, so the per-slot writes never compete for it.
  always_ff @(posedge pclk) begin
    for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
      if (commit_we[i]) begin
        mem[{page, 4'(i)}] <= pbuf[i];
      end
    end
  end

endmodule : eep_two_wire

`default_nettype wire

//--- eep_defines.svh
// Constants for the two-wire serial EEPROM target: offsets, fields, reset values and timing.
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define EEP_CTRL_OFFSET     12'h000
`define EEP_STATUS_OFFSET   12'h004
`define EEP_CTRL_EN_BIT     0
`define EEP_CTRL_RESET      1'b1
`define EEP_STAT_BUSY_BIT   0
`define EEP_STAT_WP_BIT     1
`define EEP_STAT_ADDR_LSB   16
`define EEP_STAT_ADDR_MSB   26

// ****************************************************************
// Array geometry and timing
// ****************************************************************
`define EEP_ADDR_W          11
`define EEP_DEPTH           2048
`define EEP_PAGE_BYTES      16
`define EEP_BIT_LAST        4'h8
`define EEP_PROG_TIME_MS    5
`define EEP_CLK_KHZ         25000
`define EEP_SYNC_EDGES      3

`endif

//--- eep_pkg.sv
// Types shared by the two-wire serial EEPROM target.
`default_nettype none
package eep_pkg;

  typedef enum logic [2:0] {
    EEP_IDLE,
    EEP_DEV_ADDR,
    EEP_MEM_ADDR,
    EEP_WR_DATA,
    EEP_ACK,
    EEP_RD_DATA,
    EEP_HOST_ACK
  } eep_state_type;

endpackage : eep_pkg

`default_nettype wire

//--- eep_two_wire_assertions.sv
// Concurrent checks on the pins and APB port of the two-wire EEPROM target.
`timescale 1ns/1ps
`default_nettype none
module eep_two_wire_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  a_sda_drive_low: assert property (sda_out == 1'b0) else $error("data pin driven high");
  a_ready_no_wait: assert property (psel && penable |-> pready) else $error("access phase stalled");
  a_err_unmapped: assert property (psel && penable |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("error flag wrong for address");
  a_err_zero_data: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  // The drive may only move a few cycles after the clock pin went low.
  a_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2))
    else $error("data drive changed outside clock low");
  a_start_silent: assert property (s_start |=> !sda_oe [*8]) else $error("drive right after start");
  a_stop_silent: assert property (s_stop |=> !sda_oe [*8]) else $error("drive right after stop");
  a_ack_full_bit: assert property ($rose(sda_oe) |-> sda_oe [*6]) else $error("low drive too short");
endmodule : eep_two_wire_chk
bind eep_two_wire eep_two_wire_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

//--- eep_host_model.sv
// Behavioural two-wire bus controller: makes the serial clock and pulls the data line.
`timescale 1ns/1ps
`default_nettype none
module eep_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // The clock stands high between frames; the line is released so the pull-up holds it high.
  // Pins move by non-blocking assignment, so a change that lands on a pclk edge is seen after it.
  task automatic start_c;
    #80 sda_low <= 1'b0;
    #160 scl <= 1'b1;
    #80 sda_low <= 1'b1;
    #80 scl <= 1'b0;
  endtask : start_c
  task automatic stop_c;
    #80 sda_low <= 1'b1;
    #160 scl <= 1'b1;
    #80 sda_low <= 1'b0;
    #160;
  endtask : stop_c
  // Eight bits most significant first, then the ninth bit; a one releases the line.
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic [8:0] sh;
    sh = {d, ack_in};
    // A bit takes 320 ns here to keep the run short; the target only needs four pclk per half period.
    for (int i = 8; i >= 0; i--) begin
      #40 sda_low <= !sh[i];
      #120 scl <= 1'b1;
      #80 sh[i] = sda;
      #80 scl <= 1'b0;
    end
    q = sh[8:1];
    ack = sh[0];
  endtask : xfer
endmodule : eep_host_model
`default_nettype wire

//--- eep_two_wire_tb.sv
// Self-checking bench for the two-wire EEPROM target.
`timescale 1ns/1ps
`default_nettype none
module eep_two_wire_tb;
  localparam int         PROG = 200;
  localparam logic [3:0] TC   = 4'h5; // Arbitrary type code.
  logic        pclk, presetn, psel, penable, pwrite, wp, scl, host_low, err;
  logic        pready, pslverr, sda_out, sda_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q32;
  int          failures, n_tests;
  wire         sda = !((sda_oe && !sda_out) || host_low);
  always #20 pclk = ~pclk;
  eep_two_wire #(.PROG_CYCLES(PROG), .TYPE_CODE(TC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(wp));
  eep_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q32 = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wb(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic       a;
    host.xfer(d, 1'b1, q, a);
    chk({31'h0, a}, {31'h0, ea});
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic ha);
    logic [7:0] q;
    logic       a;
    host.xfer(8'hff, ha, q, a);
    chk({24'h0, q}, {24'h0, e});
  endtask : rb
  task automatic seek(input logic [10:0] a);
    host.start_c();
    wb({TC, a[10:8], 1'b0}, 1'b0);
    wb(a[7:0], 1'b0);
  endtask : seek
  // The bound of 100 three-cycle polls keeps the wait about one and a half times the programming time.
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      k++;
    end while (q32[0] !== 1'b0 && k < 100);
    chk({31'h0, q32[0]}, 32'h0);
  endtask : wait_idle
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, wp, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(q32, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    seek(11'h7ff);
    wb(8'h5a, 1'b0);
    host.stop_c();
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, q32[0]}, 32'h1);
    host.start_c();
    wb({TC, 4'h0}, 1'b1);
    host.stop_c();
    wait_idle();
    seek(11'h00e);
    wb(8'h11, 1'b0);
    wb(8'h22, 1'b0);
    wb(8'h33, 1'b0);
    host.stop_c();
    wait_idle();
    @(posedge pclk);
    wp <= 1'b1;
    seek(11'h7ff);
    wb(8'hc3, 1'b0);
    host.stop_c();
    wait_idle();
    chk({31'h0, q32[1]}, 32'h1);
    seek(11'h7ff);
    host.start_c();
    wb({TC, 4'hf}, 1'b0);
    rb(8'h5a, 1'b0);
    rb(8'h33, 1'b1);
    rb(8'hff, 1'b1);
    host.stop_c();
    seek(11'h00e);
    host.start_c();
    wb({TC, 4'h1}, 1'b0);
    rb(8'h11, 1'b0);
    rb(8'h22, 1'b1);
    host.stop_c();
    apb(1'b0, 12'h004, 32'h0);
    chk({21'h0, q32[26:16]}, 32'h10);
    host.start_c();
    wb({~TC, 4'h0}, 1'b1);
    host.stop_c();
    apb(1'b1, 12'h000, 32'h0);
    host.start_c();
    wb({TC, 4'h0}, 1'b1);
    host.stop_c();
    apb(1'b1, 12'h000, 32'h1);
    final_report();
  end
  initial begin
    #1_000_000;
    failures++;
    final_report();
  end
endmodule : eep_two_wire_tb
`default_nettype wire
